// ---- hdl/reg_field_pkg.sv ----
// register field library package: offsets, bit positions, reset values
// assumes a 32-bit apb slave with byte addresses, one word per register
package reg_field_pkg;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] ADDR_STATUS   = 12'h000;
    localparam logic [11:0] ADDR_CTRL     = 12'h004;
    localparam logic [11:0] ADDR_LOCK     = 12'h008;
    localparam logic [11:0] ADDR_WO       = 12'h00C;
    localparam logic [11:0] ADDR_EVT      = 12'h010;
    localparam logic [11:0] ADDR_MULTI    = 12'h014;
    localparam logic [11:0] ADDR_TRIG     = 12'h018;
    localparam logic [11:0] ADDR_TRIG_CLR = 12'h01C;
    localparam logic [11:0] ADDR_FIFO     = 12'h020;
    localparam logic [11:0] ADDR_FIFO_ST  = 12'h024;
    localparam logic [11:0] ADDR_BASE     = 12'h028;
    localparam logic [11:0] ADDR_SET      = 12'h02C;
    localparam logic [11:0] ADDR_CLR      = 12'h030;

    // ****************************************
    // field positions
    // ****************************************
    localparam int EVT_SS  = 0;
    localparam int EVT_RC  = 1;
    localparam int EVT_RS  = 2;
    localparam int EVT_W1S = 3;
    localparam int EVT_W0S = 4;
    localparam int EVT_WS  = 5;
    localparam int EVT_WC  = 6;
    localparam int EVT_W1T = 7;
    localparam int EVT_W0T = 8;
    localparam int EVT_W   = 9;
    localparam int TRIG_BIT      = 0;
    localparam int LOCK_BIT      = 0;
    localparam int FIFO_FULL_BIT = 8;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [15:0] WO_RST      = 16'h0000;
    localparam logic [8:0]  EVT_RST     = 9'h000;
    localparam logic [7:0]  ZERO_RST    = 8'h00;
    localparam logic [7:0]  REFRESH_RST = 8'h00;
    localparam logic [31:0] BASE_RST    = 32'h0000_0000;
    localparam logic [15:0] HRO_RST     = 16'h00A5;

    // ****************************************
    // decoded register select
    // ****************************************
    typedef enum logic [3:0] {
        SEL_NONE, SEL_STATUS, SEL_CTRL, SEL_LOCK, SEL_WO, SEL_EVT, SEL_MULTI,
        SEL_TRIG, SEL_TRIG_CLR, SEL_FIFO, SEL_FIFO_ST, SEL_BASE, SEL_SET, SEL_CLR
    } reg_sel_e;

endpackage : reg_field_pkg

// ---- hdl/push_fifo.sv ----
// flip-flop fifo fed by the push field of the register bank
// assumes the drain side is on the same clock
`timescale 1ns/1ps
module push_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8,
    parameter int CNT_W = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_reset,
    // fill side
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_full,
    output logic [CNT_W-1:0]      o_count,
    // drain side
    output logic                  o_valid,
    output logic [WIDTH-1:0]      o_data,
    input  wire logic             i_ready
);
    localparam int PTR_W = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || CNT_W < $clog2(DEPTH + 1)) begin : g_bad_depth
        $error("push_fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic             do_push;
    logic             do_pop;

    assign o_full  = (count_reg == CNT_W'(DEPTH));
    assign o_valid = (count_reg != '0);
    assign o_count = count_reg;
    assign o_data  = mem_reg[rd_ptr_reg];
    assign do_push = i_push && !o_full;
    assign do_pop  = o_valid && i_ready;

    // ****************************************
    // storage
    // ****************************************
    always_ff @(posedge i_ref_clk) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end

    // ****************************************
    // pointers and level
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule : push_fifo

// ---- hdl/register_field_bank.sv ----
// apb register bank built from the library of field access behaviours
// assumes a zero-wait apb master on i_ref_clk; event inputs come from
// logic on the same clock, so none of them is synchronised
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

// Behaviour
// - read-only field returns its live value, bus writes to it ignored
// - write-only field takes bus writes, software cannot read it back
// - hardware-only field holds a default for internal logic, never on bus
// - write-once lock accepts one write of 1, zero writes do nothing
// - self-set flag forced to 1 by its hardware event
// - self-zeroing fields, single or multi bit, cleared by hardware event
// - self-refresh field loaded with a new value on its hardware event
// - read-sets field becomes 1 after any bus read of it
// - read-to-clear field becomes 0 after any bus read of it
// - write-any-to-set field sets on any write
// - write-one-to-set field sets on 1, ignores 0
// - write-zero-to-set field sets on 0, ignores 1
// - write-any-to-clear field clears on any write
// - write-one-to-clear field clears on 1, ignores 0
// - write-zero-to-clear field clears on 0, ignores 1
// - trigger field makes one-cycle pulse on write of 1, stores nothing
// - trigger-cleared field cleared when its trigger gets a 1
// - write-one-to-toggle field inverts on 1, ignores 0
// - write-zero-to-toggle field inverts on 0, ignores 1
// - lock-gated field writable only while its lock is inactive
// - fifo push field pushes each written word into the fifo
// - set and clear aliases set or clear base bits written as 1
module register_field_bank #(
    parameter int          FIFO_DEPTH  = 8,
    parameter logic [15:0] HRO_DEFAULT = reg_field_pkg::HRO_RST
) (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // peripheral events and status
    input  wire logic [15:0] i_hw_status,
    input  wire logic        i_evt_set,
    input  wire logic        i_evt_clr,
    input  wire logic        i_refresh_evt,
    input  wire logic [7:0]  i_refresh_val,
    // peripheral controls
    output logic [7:0]       o_ctrl_cfg,
    output logic             o_lock,
    output logic [15:0]      o_wo_value,
    output logic [15:0]      o_hro_value,
    output logic [8:0]       o_evt_flags,
    output logic [7:0]       o_zero_field,
    output logic [7:0]       o_refresh_field,
    output logic             o_trig_pulse,
    output logic             o_trig_cleared,
    output logic [31:0]      o_base_value,
    // fifo drain
    output logic             o_fifo_valid,
    output logic [31:0]      o_fifo_data,
    input  wire logic        i_fifo_ready
);
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    if (CNT_W > reg_field_pkg::FIFO_FULL_BIT) begin : g_bad_depth
        $error("fifo depth too large for the level field");
    end

    // ****************************************
    // address decode
    // ****************************************
    function automatic reg_field_pkg::reg_sel_e sel_of(input logic [11:0] addr);
        unique case (addr)
            reg_field_pkg::ADDR_STATUS:   sel_of = reg_field_pkg::SEL_STATUS;
            reg_field_pkg::ADDR_CTRL:     sel_of = reg_field_pkg::SEL_CTRL;
            reg_field_pkg::ADDR_LOCK:     sel_of = reg_field_pkg::SEL_LOCK;
            reg_field_pkg::ADDR_WO:       sel_of = reg_field_pkg::SEL_WO;
            reg_field_pkg::ADDR_EVT:      sel_of = reg_field_pkg::SEL_EVT;
            reg_field_pkg::ADDR_MULTI:    sel_of = reg_field_pkg::SEL_MULTI;
            reg_field_pkg::ADDR_TRIG:     sel_of = reg_field_pkg::SEL_TRIG;
            reg_field_pkg::ADDR_TRIG_CLR: sel_of = reg_field_pkg::SEL_TRIG_CLR;
            reg_field_pkg::ADDR_FIFO:     sel_of = reg_field_pkg::SEL_FIFO;
            reg_field_pkg::ADDR_FIFO_ST:  sel_of = reg_field_pkg::SEL_FIFO_ST;
            reg_field_pkg::ADDR_BASE:     sel_of = reg_field_pkg::SEL_BASE;
            reg_field_pkg::ADDR_SET:      sel_of = reg_field_pkg::SEL_SET;
            reg_field_pkg::ADDR_CLR:      sel_of = reg_field_pkg::SEL_CLR;
            default:                      sel_of = reg_field_pkg::SEL_NONE;
        endcase
    endfunction : sel_of

    reg_field_pkg::reg_sel_e cur_sel;
    logic                    access;
    logic                    wr_done;
    logic                    rd_done;
    logic                    fifo_full;
    logic [CNT_W-1:0]        fifo_count;
    logic [31:0]             rdata_next;
    logic [31:0]             prdata_reg;
    logic [7:0]              ctrl_reg;
    logic                    lock_reg;
    logic [15:0]             wo_reg;
    logic [8:0]              evt_reg;
    logic [8:0]              evt_next;
    logic [7:0]              zero_reg;
    logic [7:0]              refresh_reg;
    logic                    trig_reg;
    logic                    trig_clr_reg;
    logic [31:0]             base_reg;

    assign cur_sel = sel_of(i_paddr);
    assign access  = i_psel && i_penable;
    // push stalls the access while the fifo is full
    assign o_pready  = !(cur_sel == reg_field_pkg::SEL_FIFO && i_pwrite && fifo_full);
    assign o_pslverr = access && (cur_sel == reg_field_pkg::SEL_NONE);
    assign wr_done   = access && o_pready && i_pwrite;
    assign rd_done   = access && o_pready && !i_pwrite;
    assign o_prdata  = prdata_reg;

    // ****************************************
    // read data, captured in the setup cycle
    // ****************************************
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (cur_sel)
            reg_field_pkg::SEL_STATUS:   rdata_next[15:0] = i_hw_status;
            reg_field_pkg::SEL_CTRL:     rdata_next[7:0] = ctrl_reg;
            reg_field_pkg::SEL_LOCK:     rdata_next[reg_field_pkg::LOCK_BIT] = lock_reg;
            reg_field_pkg::SEL_EVT:      rdata_next[8:0] = evt_reg;
            reg_field_pkg::SEL_MULTI:    rdata_next = {8'h00, refresh_reg, 8'h00, zero_reg};
            reg_field_pkg::SEL_TRIG_CLR: rdata_next[0] = trig_clr_reg;
            reg_field_pkg::SEL_FIFO_ST: begin
                rdata_next[CNT_W-1:0] = fifo_count;
                rdata_next[reg_field_pkg::FIFO_FULL_BIT] = fifo_full;
            end
            reg_field_pkg::SEL_BASE:     rdata_next = base_reg;
            reg_field_pkg::SEL_WO, reg_field_pkg::SEL_TRIG, reg_field_pkg::SEL_FIFO,
            reg_field_pkg::SEL_SET, reg_field_pkg::SEL_CLR, reg_field_pkg::SEL_NONE: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            prdata_reg <= 32'h0000_0000;
        end else if (i_psel && !i_penable) begin
            prdata_reg <= rdata_next;
        end
    end

    // ****************************************
    // lock and lock-gated control
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            lock_reg <= 1'b0;
        end else if (wr_done && cur_sel == reg_field_pkg::SEL_LOCK
                     && i_pwdata[reg_field_pkg::LOCK_BIT]) begin
            lock_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_reg <= reg_field_pkg::CTRL_RST;
        end else if (wr_done && cur_sel == reg_field_pkg::SEL_CTRL && !lock_reg) begin
            ctrl_reg <= i_pwdata[7:0];
        end
    end

    // ****************************************
    // write-only value
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            wo_reg <= reg_field_pkg::WO_RST;
        end else if (wr_done && cur_sel == reg_field_pkg::SEL_WO) begin
            wo_reg <= i_pwdata[15:0];
        end
    end

    // ****************************************
    // event flags, set wins over clear
    // ****************************************
    logic evt_wr;
    logic evt_rd;
    logic [8:0] w;
    assign evt_wr = wr_done && cur_sel == reg_field_pkg::SEL_EVT;
    assign evt_rd = rd_done && cur_sel == reg_field_pkg::SEL_EVT;
    assign w      = i_pwdata[8:0];

    always_comb begin
        evt_next = evt_reg;
        evt_next[reg_field_pkg::EVT_SS] = i_evt_set
            || (evt_reg[reg_field_pkg::EVT_SS] && !(evt_wr && w[reg_field_pkg::EVT_SS]));
        evt_next[reg_field_pkg::EVT_RC] = i_evt_set
            || (evt_reg[reg_field_pkg::EVT_RC] && !evt_rd);
        evt_next[reg_field_pkg::EVT_RS] = evt_rd
            || (evt_reg[reg_field_pkg::EVT_RS] && !(evt_wr && !w[reg_field_pkg::EVT_RS]));
        evt_next[reg_field_pkg::EVT_W1S] = (evt_wr && w[reg_field_pkg::EVT_W1S])
            || (evt_reg[reg_field_pkg::EVT_W1S] && !i_evt_clr);
        evt_next[reg_field_pkg::EVT_W0S] = (evt_wr && !w[reg_field_pkg::EVT_W0S])
            || (evt_reg[reg_field_pkg::EVT_W0S] && !i_evt_clr);
        evt_next[reg_field_pkg::EVT_WS] = evt_wr
            || (evt_reg[reg_field_pkg::EVT_WS] && !i_evt_clr);
        evt_next[reg_field_pkg::EVT_WC] = i_evt_set
            || (evt_reg[reg_field_pkg::EVT_WC] && !evt_wr);
        evt_next[reg_field_pkg::EVT_W1T] = evt_reg[reg_field_pkg::EVT_W1T]
            ^ (evt_wr && w[reg_field_pkg::EVT_W1T]);
        evt_next[reg_field_pkg::EVT_W0T] = evt_reg[reg_field_pkg::EVT_W0T]
            ^ (evt_wr && !w[reg_field_pkg::EVT_W0T]);
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            evt_reg <= reg_field_pkg::EVT_RST;
        end else begin
            evt_reg <= evt_next;
        end
    end

    // ****************************************
    // multi-bit hardware-updated fields
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            zero_reg <= reg_field_pkg::ZERO_RST;
        end else if (i_evt_clr) begin
            zero_reg <= 8'h00;
        end else if (wr_done && cur_sel == reg_field_pkg::SEL_MULTI) begin
            zero_reg <= i_pwdata[7:0];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            refresh_reg <= reg_field_pkg::REFRESH_RST;
        end else if (i_refresh_evt) begin
            refresh_reg <= i_refresh_val;
        end else if (wr_done && cur_sel == reg_field_pkg::SEL_MULTI) begin
            refresh_reg <= i_pwdata[23:16];
        end
    end

    // ****************************************
    // trigger and trigger-cleared field
    // ****************************************
    logic trig_wr;
    assign trig_wr = wr_done && cur_sel == reg_field_pkg::SEL_TRIG
                     && i_pwdata[reg_field_pkg::TRIG_BIT];

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            trig_reg <= 1'b0;
        end else begin
            trig_reg <= trig_wr;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            trig_clr_reg <= 1'b0;
        end else if (i_evt_set) begin
            trig_clr_reg <= 1'b1;
        end else if (trig_wr) begin
            trig_clr_reg <= 1'b0;
        end
    end

    // ****************************************
    // base register and its aliases
    // ****************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            base_reg <= reg_field_pkg::BASE_RST;
        end else if (wr_done) begin
            unique case (cur_sel)
                reg_field_pkg::SEL_BASE: base_reg <= i_pwdata;
                reg_field_pkg::SEL_SET:  base_reg <= base_reg | i_pwdata;
                reg_field_pkg::SEL_CLR:  base_reg <= base_reg & ~i_pwdata;
                default:                 base_reg <= base_reg;
            endcase
        end
    end

    // ****************************************
    // fifo push field
    // ****************************************
    // write pushes word
    push_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH),
        .CNT_W (CNT_W)
    ) u_push_fifo (
        .i_ref_clk (i_ref_clk),
        .i_reset   (i_reset),
        .i_push    (wr_done && cur_sel == reg_field_pkg::SEL_FIFO),
        .i_data    (i_pwdata),
        .o_full    (fifo_full),
        .o_count   (fifo_count),
        .o_valid   (o_fifo_valid),
        .o_data    (o_fifo_data),
        .i_ready   (i_fifo_ready)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign o_ctrl_cfg      = ctrl_reg;
    assign o_lock          = lock_reg;
    assign o_wo_value      = wo_reg;
    assign o_hro_value     = HRO_DEFAULT;
    assign o_evt_flags     = evt_reg;
    assign o_zero_field    = zero_reg;
    assign o_refresh_field = refresh_reg;
    assign o_trig_pulse    = trig_reg;
    assign o_trig_cleared  = trig_clr_reg;
    assign o_base_value    = base_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);

    chk_ro_live_read: assert property (
        rd_done && cur_sel == reg_field_pkg::SEL_STATUS |-> o_prdata[15:0] == $past(i_hw_status))
        else $error("status read does not show live value");
    chk_wo_read_zero: assert property (
        rd_done && cur_sel == reg_field_pkg::SEL_WO |-> o_prdata == 32'h0000_0000)
        else $error("write-only register read back nonzero");
    chk_lock_sticks: assert property (
        lock_reg |=> lock_reg [*3])
        else $error("write-once lock changed");
    chk_self_set: assert property (
        i_evt_set |=> evt_reg[reg_field_pkg::EVT_SS] && evt_reg[reg_field_pkg::EVT_RC])
        else $error("self-set flag missed event");
    chk_zero_field: assert property (
        i_evt_clr |=> zero_reg == 8'h00)
        else $error("self-zeroing field not cleared");
    chk_refresh_load: assert property (
        i_refresh_evt |=> refresh_reg == $past(i_refresh_val))
        else $error("self-refresh field not loaded");
    chk_read_sets: assert property (
        rd_done && cur_sel == reg_field_pkg::SEL_EVT |=> evt_reg[reg_field_pkg::EVT_RS])
        else $error("read-sets field not set");
    chk_read_clears: assert property (
        rd_done && cur_sel == reg_field_pkg::SEL_EVT && !i_evt_set
        |=> !evt_reg[reg_field_pkg::EVT_RC])
        else $error("read-to-clear field not cleared");
    chk_trig_single: assert property (
        trig_wr |=> o_trig_pulse ##1 !o_trig_pulse || trig_wr)
        else $error("trigger pulse wrong length");
    chk_trig_clears: assert property (
        trig_wr && !i_evt_set |=> !trig_clr_reg)
        else $error("trigger-cleared field survived trigger");
    chk_toggle_one: assert property (
        evt_wr && w[reg_field_pkg::EVT_W1T]
        |=> evt_reg[reg_field_pkg::EVT_W1T] != $past(evt_reg[reg_field_pkg::EVT_W1T]))
        else $error("toggle field did not invert");
    chk_lock_gate: assert property (
        lock_reg |=> $stable(ctrl_reg))
        else $error("locked control changed");
    chk_alias_set: assert property (
        wr_done && cur_sel == reg_field_pkg::SEL_SET
        |=> (base_reg & $past(i_pwdata)) == $past(i_pwdata))
        else $error("set alias missed a bit");

    cov_fifo_stall: cover property (i_psel && i_penable && !o_pready);
    cov_lock_write: cover property (lock_reg && wr_done && cur_sel == reg_field_pkg::SEL_CTRL);
    cov_set_clear_race: cover property (i_evt_set && evt_wr && w[reg_field_pkg::EVT_SS]);
    cov_trigger: cover property (o_trig_pulse);

endmodule : register_field_bank

// ---- tb/apb_host.sv ----
// apb master model that stands for the processor
// assumes one clock; slave completes through pready
`timescale 1ns/1ps
module apb_host (
    // bus
    input  wire logic        i_ref_clk,
    input  wire logic        i_pready,
    input  wire logic [31:0] i_prdata,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [11:0]      o_paddr,
    output logic [31:0]      o_pwdata
);
    initial begin
        o_psel = 1'h0;
        o_penable = 1'h0;
        o_pwrite = 1'h0;
        o_paddr = 12'h0;
        o_pwdata = 32'h0;
    end
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
              output logic [31:0] r);
        @(posedge i_ref_clk);
        o_psel <= 1'h1;
        o_pwrite <= w;
        o_paddr <= a;
        o_pwdata <= d;
        @(posedge i_ref_clk);
        o_penable <= 1'h1;
        do @(posedge i_ref_clk); while (i_pready !== 1'h1);
        r = i_prdata;
        o_psel <= 1'h0;
        o_penable <= 1'h0;
    endtask : xfer
endmodule : apb_host

// ---- tb/register_field_bank_tb_top.sv ----
// bench for the register field bank
// assumes the apb_host model drives the bus
`timescale 1ns/1ps
module register_field_bank_tb_top;
    logic clk = 1'h0, rst = 1'h1, ps, pe, pw, rdy, es = 1'h0, ec = 1'h0, re = 1'h0;
    logic        trg, tcl, lk, fv, se, sl, fr = 1'h0;
    logic [11:0] pa;
    logic [31:0] wd, rdat, r, fd, bv;
    logic [15:0] wo, hardware_only_readable, hs = 16'h1234;
    logic [8:0]  ev;
    logic [7:0]  zf, rf, cf;
    int          err_count = 0, compares = 0;
    always #25 clk = ~clk;
    // error flag of the last completed transfer
    always @(posedge clk) begin
        if (ps && pe && rdy) begin
            sl <= se;
        end
    end
    apb_host m (.i_ref_clk(clk), .i_pready(rdy), .i_prdata(rdat), .o_psel(ps),
        .o_penable(pe), .o_pwrite(pw), .o_paddr(pa), .o_pwdata(wd));
    register_field_bank uut (.i_ref_clk(clk), .i_reset(rst), .i_psel(ps), .i_penable(pe),
        .i_pwrite(pw), .i_paddr(pa), .i_pwdata(wd), .o_prdata(rdat), .o_pready(rdy),
        .o_pslverr(se), .i_hw_status(hs), .i_evt_set(es), .i_evt_clr(ec),
        .i_refresh_evt(re), .i_refresh_val(8'h3C), .o_ctrl_cfg(cf), .o_lock(lk),
        .o_wo_value(wo), .o_hro_value(hardware_only_readable), .o_evt_flags(ev), .o_zero_field(zf),
        .o_refresh_field(rf), .o_trig_pulse(trg), .o_trig_cleared(tcl),
        .o_base_value(bv), .o_fifo_valid(fv), .o_fifo_data(fd), .i_fifo_ready(fr));
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        m.xfer(1'h1, a, d, r);
        #1;
    endtask : wr
    task rd(input logic [11:0] a);
        m.xfer(1'h0, a, 32'h0, r);
        #1;
    endtask : rd
    task final_report;
        if (err_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    task hw(input logic s, input logic c);
        @(posedge clk);
        es <= s;
        ec <= c;
        re <= c;
        @(posedge clk);
        es <= 1'h0;
        ec <= 1'h0;
        re <= 1'h0;
        #1;
    endtask : hw
    initial begin
        #200000;
        err_count++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        wr(12'h000, 32'hFFFF);
        rd(12'h000);
        chk(r, 32'h1234);
        chk(sl, 1'h0);
        @(posedge clk);
        hs <= 16'h8001;
        rd(12'h000);
        chk(r, 32'h8001);
        rd(12'h040);
        chk(r, 32'h0);
        chk(sl, 1'h1);
        wr(12'h00C, 32'hBEEF);
        chk(wo, 32'hBEEF);
        rd(12'h00C);
        chk(r, 32'h0);
        chk(hardware_only_readable, 32'hA5);
        wr(12'h004, 32'h5A);
        wr(12'h008, 32'h0);
        chk(lk, 1'h0);
        wr(12'h008, 32'h1);
        wr(12'h004, 32'h33);
        wr(12'h008, 32'h0);
        chk(lk, 1'h1);
        rd(12'h004);
        chk(r, 32'h5A);
        chk(cf, 32'h5A);
        hw(1'h1, 1'h0);
        chk(ev, 9'h043);
        chk(tcl, 1'h1);
        rd(12'h010);
        chk(r, 32'h043);
        chk(ev, 9'h045);
        wr(12'h010, 32'h1BD);
        chk(ev, 9'h0AC);
        wr(12'h010, 32'h0);
        chk(ev, 9'h1B8);
        wr(12'h014, 32'hFF);
        hw(1'h0, 1'h1);
        chk(ev, 9'h180);
        chk(zf, 8'h0);
        chk(rf, 8'h3C);
        wr(12'h018, 32'h1);
        chk(trg, 1'h1);
        chk(tcl, 1'h0);
        @(posedge clk);
        #1;
        chk(trg, 1'h0);
        wr(12'h020, 32'hCAFEF00D);
        chk(fd, 32'hCAFEF00D);
        chk(fv, 1'h1);
        for (int i = 1; i < 8; i++) begin
            wr(12'h020, i);
        end
        rd(12'h024);
        chk(r, 32'h108);
        // push into a full fifo stalls until one word is drained
        fork
            wr(12'h020, 32'h99);
            begin
                repeat (4) @(posedge clk);
                fr <= 1'h1;
                @(posedge clk);
                fr <= 1'h0;
            end
        join
        chk(fd, 32'h1);
        rd(12'h024);
        chk(r, 32'h108);
        wr(12'h028, 32'hF0);
        wr(12'h02C, 32'h0F);
        wr(12'h030, 32'h30);
        chk(bv, 32'hCF);
        final_report();
    end
endmodule : register_field_bank_tb_top
